// File: logic/ras_top.sv
// return address stack, program counter and vectoring with Avalon-MM registers
//
// Our own choices: the address map and the Avalon-MM slave port.
`include "ras_consts.svh"
module ras_top
	import ras_pkg::*;
#(
	parameter int DEPTH = `RAS_DEPTH,
	parameter int IMPL_BYTES = `RAS_IMPL_BYTES
) (
	input wire logic i_mclk,
	input wire logic i_arst_n,
	input wire logic i_dev_reset,
	input wire logic [4:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	input wire logic i_push_req,
	input wire logic i_pop_req,
	input wire logic i_pop_discard,
	input wire logic i_int_ack,
	input wire logic i_int_high,
	input wire logic i_jump_req,
	input wire logic [`RAS_PC_W-1:0] i_jump_addr,
	input wire logic i_pcl_write,
	input wire logic [7:0] i_pcl_data,
	input wire logic i_pc_step,
	output logic [`RAS_PC_W-1:0] o_pc,
	input wire logic [`RAS_INSN_W-1:0] i_pmem_rdata,
	output logic [`RAS_INSN_W-1:0] o_insn,
	output logic o_stack_reset
);
	typedef struct packed {
		ras_bus_ph_t ph;
		logic waitreq;
		logic [31:0] rdata;
		logic [`RAS_SP_W-1:0] sp;
		logic full;
		logic unf;
		logic ovr_en;
		logic [`RAS_LATU_W-1:0] lat_u;
		logic [7:0] lat_h;
		ras_pc_t pc;
		logic stk_rst;
	} ras_top_st_t;

	localparam ras_top_st_t ST_RESET = '{
		ph: RAS_BUS_IDLE, waitreq: 1'b1, rdata: '0, sp: '0, full: 1'b0, unf: 1'b0,
		ovr_en: `RAS_OVR_EN_RST, lat_u: '0, lat_h: '0, pc: `RAS_RESET_VEC, stk_rst: 1'b0};
	localparam logic [`RAS_SP_W-1:0] SP_LAST = `RAS_SP_W'(DEPTH);
	localparam logic [`RAS_SP_W-1:0] SP_PREV = `RAS_SP_W'(DEPTH - 1);

	ras_top_st_t st_ff;
	ras_top_st_t nxt_st;
	logic [31:0] rd_word;
	logic do_int;
	logic do_push;
	logic do_pop;
	logic sw_wr;
	logic [7:0] wb;
	logic lat_wr;

	// one instruction word forward; shared by the push and plain paths
	function automatic ras_pc_t pc_plus_step(input ras_pc_t cur);
		return ras_pc_t'(cur + `RAS_PC_STEP);
	endfunction

	ras_mem_if mem ();

	// 31 nesting levels, one per nonzero pointer code
	if (DEPTH != (1 << `RAS_SP_W) - 1) begin : g_chk
		$error("stack depth must fill the pointer range less the empty code");
	end

	ras_stack_mem #(
		.DEPTH(DEPTH)
	) u_mem (
		.i_mclk(i_mclk),
		.i_arst_n(i_arst_n),
		.port(mem.store)
	);

	// program fetch runs on its own port, not the register bus
	ras_fetch_gate #(
		.IMPL_BYTES(IMPL_BYTES)
	) u_fetch (
		.i_mclk(i_mclk),
		.i_arst_n(i_arst_n),
		.i_addr(st_ff.pc),
		.i_rdata(i_pmem_rdata),
		.o_insn(o_insn)
	);

	// hardware stack events in priority order; any reset source beats all
	assign do_int = !i_dev_reset && i_int_ack;
	assign do_push = !i_dev_reset && !i_int_ack && i_push_req;
	assign do_pop = !i_dev_reset && !i_int_ack && !i_push_req && (i_pop_req || i_pop_discard);
	assign sw_wr = st_ff.ph == RAS_BUS_ACK && i_avs_write && i_avs_byteenable[0];
	assign wb = i_avs_writedata[7:0];
	assign lat_wr = sw_wr &&
		(i_avs_address == `RAS_OFF_LATH || i_avs_address == `RAS_OFF_LATU);
	assign mem.rd_ptr = st_ff.sp;

	always_comb begin
		rd_word = '0;
		if (i_avs_address == `RAS_OFF_SP) begin
			rd_word[`RAS_BIT_FULL] = st_ff.full;
			rd_word[`RAS_BIT_UNF] = st_ff.unf;
			rd_word[`RAS_SP_W-1:0] = st_ff.sp;
		// byte views of the top entry
		end else if (i_avs_address == `RAS_OFF_TOP_ENTRY_LOW_BYTE) begin
			rd_word[7:0] = mem.rd_data[7:0];
		end else if (i_avs_address == `RAS_OFF_TOP_ENTRY_HIGH_BYTE) begin
			rd_word[7:0] = mem.rd_data[15:8];
		end else if (i_avs_address == `RAS_OFF_TOP_ENTRY_UPPER_BYTE) begin
			rd_word[4:0] = mem.rd_data[20:16];
		end else if (i_avs_address == `RAS_OFF_CTRL) begin
			rd_word[`RAS_BIT_OVR] = st_ff.ovr_en;
		end else if (i_avs_address == `RAS_OFF_LATH) begin
			rd_word[7:0] = st_ff.lat_h;
		end else if (i_avs_address == `RAS_OFF_LATU) begin
			rd_word[`RAS_LATU_W-1:0] = st_ff.lat_u;
		end else if (i_avs_address == `RAS_OFF_PC) begin
			rd_word[`RAS_PC_W-1:0] = st_ff.pc;
		end
	end

	// next state: bus handshake, software writes, then core stack events
	always_comb begin
		nxt_st = st_ff;
		nxt_st.stk_rst = 1'b0;
		mem.wr_ptr = st_ff.sp;
		mem.wr_be = '0;
		mem.wr_data = '0;
		// one wait cycle per access; read data is caught when the request is seen
		case (st_ff.ph)
			RAS_BUS_IDLE: begin
				if (i_avs_read || i_avs_write) begin
					nxt_st.ph = RAS_BUS_ACK;
					nxt_st.waitreq = 1'b0;
					nxt_st.rdata = rd_word;
				end
			end
			RAS_BUS_ACK: begin
				nxt_st.ph = RAS_BUS_IDLE;
				nxt_st.waitreq = 1'b1;
			end
			default: begin
				nxt_st.ph = RAS_BUS_IDLE;
				nxt_st.waitreq = 1'b1;
			end
		endcase
		// software pointer write; flags clear only on a written zero
		if (sw_wr && i_avs_address == `RAS_OFF_SP) begin
			nxt_st.sp = wb[`RAS_SP_W-1:0];
			if (!wb[`RAS_BIT_FULL]) nxt_st.full = 1'b0;
			if (!wb[`RAS_BIT_UNF]) nxt_st.unf = 1'b0;
		end
		// one byte lane of the current top entry
		if (sw_wr && i_avs_address == `RAS_OFF_TOP_ENTRY_LOW_BYTE) mem.wr_be = `RAS_BE_LOW;
		if (sw_wr && i_avs_address == `RAS_OFF_TOP_ENTRY_HIGH_BYTE) mem.wr_be = `RAS_BE_HIGH;
		if (sw_wr && i_avs_address == `RAS_OFF_TOP_ENTRY_UPPER_BYTE) mem.wr_be = `RAS_BE_UPPER;
		mem.wr_data = {wb[4:0], wb, wb};
		if (sw_wr && i_avs_address == `RAS_OFF_CTRL) nxt_st.ovr_en = wb[`RAS_BIT_OVR];
		if (sw_wr && i_avs_address == `RAS_OFF_LATH) nxt_st.lat_h = wb;
		if (sw_wr && i_avs_address == `RAS_OFF_LATU) nxt_st.lat_u = wb[`RAS_LATU_W-1:0];
		// any reset source empties the stack
		if (i_dev_reset) begin
			nxt_st.sp = '0;
			nxt_st.pc = `RAS_RESET_VEC;
		end else if (do_int || do_push) begin
			// current PC goes onto the stack
			mem.wr_be = '1;
			mem.wr_data = st_ff.pc;
			if (st_ff.sp == SP_LAST) begin
				// pointer parked at the top, entry overwritten
				mem.wr_ptr = st_ff.sp;
			end else begin
				// increment first, write at the new pointer
				mem.wr_ptr = `RAS_SP_W'(st_ff.sp + 1'b1);
				nxt_st.sp = mem.wr_ptr;
			end
			// full at or beyond the last level
			if (st_ff.sp >= SP_PREV) nxt_st.full = 1'b1;
			if (st_ff.sp == SP_PREV && st_ff.ovr_en) begin
				// store PC+2, keep full, reset the device
				mem.wr_data = pc_plus_step(st_ff.pc);
				nxt_st.stk_rst = 1'b1;
				nxt_st.sp = '0;
				nxt_st.pc = `RAS_RESET_VEC;
			end else if (do_int) begin
				nxt_st.pc = i_int_high ? `RAS_VEC_HI : `RAS_VEC_LO;
			end else if (i_jump_req) begin
				nxt_st.pc = i_jump_addr;
			end else if (i_pc_step) begin
				nxt_st.pc = pc_plus_step(st_ff.pc);
			end
		end else if (do_pop) begin
			if (st_ff.sp == '0) begin
				// empty pop goes to the reset vector
				nxt_st.pc = `RAS_RESET_VEC;
				nxt_st.unf = 1'b1;
				nxt_st.stk_rst = st_ff.ovr_en;
			end else begin
				if (i_pop_req) nxt_st.pc = mem.rd_data;
				nxt_st.sp = `RAS_SP_W'(st_ff.sp - 1'b1);
			end
		end else if (i_jump_req) begin
			nxt_st.pc = i_jump_addr;
		end else if (i_pcl_write) begin
			nxt_st.pc = {st_ff.lat_u, st_ff.lat_h, i_pcl_data};
		end else if (i_pc_step) begin
			nxt_st.pc = pc_plus_step(st_ff.pc);
		end
	end

	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st_ff <= ST_RESET;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign o_avs_readdata = st_ff.rdata;
	assign o_avs_waitrequest = st_ff.waitreq;
	assign o_pc = st_ff.pc;
	assign o_stack_reset = st_ff.stk_rst;

	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_arst_n);

	sequence s_plain_push;
		(do_int || do_push) && st_ff.sp < SP_PREV;
	endsequence
	sequence s_ovr_push;
		(do_int || do_push) && st_ff.sp == SP_PREV && st_ff.ovr_en;
	endsequence
	sequence s_bus_req;
		st_ff.ph == RAS_BUS_IDLE && (i_avs_read || i_avs_write);
	endsequence

	a_reset_src: assert property (i_dev_reset |=> st_ff.sp == '0 && o_pc == '0)
		else $error("reset source left pointer or pc set");
	a_int_vector: assert property ((do_int && !(st_ff.sp == SP_PREV && st_ff.ovr_en))
		|=> o_pc == ($past(i_int_high) ? `RAS_VEC_HI : `RAS_VEC_LO))
		else $error("interrupt did not load its vector");
	a_push_order: assert property (s_plain_push |=>
		st_ff.sp == `RAS_SP_W'($past(st_ff.sp) + 1'b1) && mem.rd_data == $past(st_ff.pc))
		else $error("push did not land at the incremented pointer");
	a_pop_order: assert property ((do_pop && i_pop_req && st_ff.sp != '0) |=>
		o_pc == $past(mem.rd_data) && st_ff.sp == `RAS_SP_W'($past(st_ff.sp) - 1'b1))
		else $error("pop order wrong");
	a_under_flow: assert property ((do_pop && st_ff.sp == '0) |=>
		st_ff.unf && st_ff.sp == '0 && o_pc == '0)
		else $error("empty pop mishandled");
	a_over_reset: assert property (s_ovr_push |=>
		o_stack_reset && st_ff.full && st_ff.sp == '0 ##1 !o_stack_reset)
		else $error("overflow reset sequence wrong");
	a_over_park: assert property (((do_int || do_push) && st_ff.sp == SP_LAST) |=>
		st_ff.sp == SP_LAST && st_ff.full)
		else $error("pointer left the top on overflow");
	a_full_sticky: assert property ((st_ff.full && !(sw_wr && i_avs_address == `RAS_OFF_SP))
		|=> st_ff.full)
		else $error("full flag dropped without software");
	a_bus_answer: assert property (s_bus_req |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
		else $error("bus answer timing wrong");
	a_latch_keep: assert property (do_pop && !lat_wr |=>
		st_ff.lat_h == $past(st_ff.lat_h) && st_ff.lat_u == $past(st_ff.lat_u))
		else $error("return changed pc latch");
endmodule

// File: logic/ras_consts.svh
// constants for the return address stack block
`ifndef RAS_CONSTS_SVH
`define RAS_CONSTS_SVH
`define RAS_PC_W 21
`define RAS_SP_W 5
`define RAS_DEPTH 31
`define RAS_IMPL_BYTES 32768
`define RAS_INSN_W 16
`define RAS_LATU_W 5
`define RAS_RESET_VEC 21'h000000
`define RAS_VEC_HI 21'h000008
`define RAS_VEC_LO 21'h000018
`define RAS_PC_STEP 21'h000002
`define RAS_OFF_SP 5'h00
`define RAS_OFF_TOP_ENTRY_LOW_BYTE 5'h04
`define RAS_OFF_TOP_ENTRY_HIGH_BYTE 5'h08
`define RAS_OFF_TOP_ENTRY_UPPER_BYTE 5'h0C
`define RAS_OFF_CTRL 5'h10
`define RAS_OFF_LATH 5'h14
`define RAS_OFF_LATU 5'h18
`define RAS_OFF_PC 5'h1C
`define RAS_BIT_FULL 7
`define RAS_BIT_UNF 6
`define RAS_BIT_OVR 0
`define RAS_OVR_EN_RST 1'b1
`define RAS_BE_LOW 3'h1
`define RAS_BE_HIGH 3'h2
`define RAS_BE_UPPER 3'h4
`endif

// File: logic/ras_pkg.sv
// shared types and helpers of the return address stack
`include "ras_consts.svh"
package ras_pkg;
	typedef logic [`RAS_PC_W-1:0] ras_pc_t;
	typedef enum logic {RAS_BUS_IDLE, RAS_BUS_ACK} ras_bus_ph_t;

	// merge the enabled bytes of a stack entry
	function automatic ras_pc_t ras_merge(input ras_pc_t old, input ras_pc_t dat,
			input logic [2:0] be);
		ras_pc_t r;
		r = old;
		if (be[0]) r[7:0] = dat[7:0];
		if (be[1]) r[15:8] = dat[15:8];
		if (be[2]) r[20:16] = dat[20:16];
		return r;
	endfunction
endpackage

// File: logic/ras_mem_if.sv
// connection between stack controller and stack storage
`include "ras_consts.svh"
interface ras_mem_if;
	logic [`RAS_SP_W-1:0] rd_ptr;
	logic [`RAS_SP_W-1:0] wr_ptr;
	logic [2:0] wr_be;
	logic [`RAS_PC_W-1:0] wr_data;
	logic [`RAS_PC_W-1:0] rd_data;
	modport ctrl (output rd_ptr, output wr_ptr, output wr_be, output wr_data, input rd_data);
	modport store (input rd_ptr, input wr_ptr, input wr_be, input wr_data, output rd_data);
endinterface

// File: logic/ras_stack_mem.sv
// stack storage, entries 1..DEPTH, no entry behind pointer zero
`include "ras_consts.svh"
module ras_stack_mem
	import ras_pkg::*;
#(
	parameter int DEPTH = `RAS_DEPTH
) (
	input wire logic i_mclk,
	input wire logic i_arst_n,
	ras_mem_if.store port
);
	typedef struct packed {
		logic [DEPTH:1][`RAS_PC_W-1:0] ent;
	} ras_mem_st_t;

	ras_mem_st_t st_ff;
	ras_mem_st_t nxt_st;

	if (DEPTH < 1 || DEPTH >= (1 << `RAS_SP_W)) begin : g_chk
		$error("stack depth does not fit the pointer");
	end

	// byte-lane writes to the addressed entry only
	always_comb begin
		nxt_st = st_ff;
		for (int i = 1; i <= DEPTH; i++) begin
			if (port.wr_be != '0 && int'(port.wr_ptr) == i) begin
				nxt_st.ent[i] = ras_merge(st_ff.ent[i], port.wr_data, port.wr_be);
			end
		end
	end

	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	always_comb begin
		port.rd_data = '0;
		for (int i = 1; i <= DEPTH; i++) begin
			if (int'(port.rd_ptr) == i) begin
				port.rd_data = st_ff.ent[i];
			end
		end
	end

	a_entry_zero: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
		port.rd_ptr == '0 |-> port.rd_data == '0)
		else $error("pointer zero returned stored data");
endmodule

// File: logic/ras_fetch_gate.sv
// instruction fetch gate: zero words beyond the implemented memory
`include "ras_consts.svh"
module ras_fetch_gate
	import ras_pkg::*;
#(
	parameter int IMPL_BYTES = `RAS_IMPL_BYTES
) (
	input wire logic i_mclk,
	input wire logic i_arst_n,
	input wire logic [`RAS_PC_W-1:0] i_addr,
	input wire logic [`RAS_INSN_W-1:0] i_rdata,
	output logic [`RAS_INSN_W-1:0] o_insn
);
	typedef struct packed {
		ras_pc_t addr_q;
		logic [`RAS_INSN_W-1:0] insn;
	} ras_fg_st_t;

	ras_fg_st_t st_ff;
	ras_fg_st_t nxt_st;

	if (IMPL_BYTES < 1 || IMPL_BYTES > (1 << `RAS_PC_W)) begin : g_chk
		$error("implemented size outside the address space");
	end

	// memory answers one edge after the address, so compare the held address
	always_comb begin
		nxt_st = st_ff;
		nxt_st.addr_q = i_addr;
		if (st_ff.addr_q < ras_pc_t'(IMPL_BYTES)) begin
			nxt_st.insn = i_rdata;
		end else begin
			nxt_st.insn = '0;
		end
	end

	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign o_insn = st_ff.insn;

	a_fetch_zero: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
		st_ff.addr_q >= ras_pc_t'(IMPL_BYTES) |=> o_insn == '0)
		else $error("fetch beyond memory returned nonzero");
endmodule

// File: sim/ras_core_model.sv
// core sequencer and program memory model facing the stack block
module ras_core_model (
	input wire logic i_mclk,
	input wire logic [20:0] i_pc,
	output logic o_dev_reset,
	output logic o_int_ack,
	output logic o_int_high,
	output logic o_push,
	output logic o_pop,
	output logic o_discard,
	output logic o_jump,
	output logic [20:0] o_jump_addr,
	output logic o_pcl_write,
	output logic [7:0] o_pcl_data,
	output logic o_step,
	output logic [15:0] o_pmem_rdata
);
	timeunit 1ns;
	timeprecision 1ns;

	// all core strobes idle from time zero
	initial begin
		{o_dev_reset, o_int_ack, o_int_high, o_push, o_pop} = 5'h00;
		{o_discard, o_jump, o_pcl_write, o_step} = 4'h0;
		o_jump_addr = 21'h000000;
		o_pcl_data = 8'h00;
	end

	// memory answers every address, so the zero words the bench expects above 32 Kbytes come from the gate
	always_ff @(posedge i_mclk) begin
		o_pmem_rdata <= i_pc[15:0] ^ 16'h5A5A;
	end

	// quiet between commands
	// one instruction event per call; strobes drop after one edge so software edits
	// of the top entry never race an unplanned push or pop
	task automatic op(input logic [8:0] sel, input logic [20:0] addr);
		@(posedge i_mclk);
		{o_dev_reset, o_int_ack, o_int_high, o_push, o_pop} <= sel[8:4];
		{o_discard, o_jump, o_pcl_write, o_step} <= sel[3:0];
		o_jump_addr <= addr;
		o_pcl_data <= addr[7:0];
		@(posedge i_mclk);
		{o_dev_reset, o_int_ack, o_int_high, o_push, o_pop} <= 5'h00;
		{o_discard, o_jump, o_pcl_write, o_step} <= 4'h0;
	endtask
endmodule

// File: sim/tb_ras_top.sv
// self-checking bench for the return address stack block
`include "ras_consts.svh"
module tb_ras_top
	import ras_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [8:0] K_RST = 9'h100;
	localparam logic [8:0] K_INT = 9'h080;
	localparam logic [8:0] K_HI = 9'h040;
	localparam logic [8:0] K_PUSH = 9'h020;
	localparam logic [8:0] K_POP = 9'h010;
	localparam logic [8:0] K_DISC = 9'h008;
	localparam logic [8:0] K_JMP = 9'h004;
	localparam logic [8:0] K_PCL = 9'h002;
	localparam logic [8:0] K_STEP = 9'h001;
	logic mclk, arst_n, dev_reset, avs_read, avs_write, avs_waitrequest;
	logic [4:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic [3:0] avs_byteenable;
	logic push, pop, discard, int_ack, int_high, jump, pcl_write, step, stack_rst;
	logic [20:0] jump_addr;
	ras_pc_t pc;
	logic [7:0] pcl_data;
	logic [15:0] pmem_rdata, insn;
	int n_mismatch = 0;
	int cmp_count = 0;
	int cycles = 0;
	int n_srst = 0;

	ras_top i_ras_top (.i_mclk(mclk), .i_arst_n(arst_n), .i_dev_reset(dev_reset),
		.i_avs_address(avs_address), .i_avs_read(avs_read), .i_avs_write(avs_write),
		.i_avs_writedata(avs_writedata), .i_avs_byteenable(avs_byteenable),
		.o_avs_readdata(avs_readdata), .o_avs_waitrequest(avs_waitrequest),
		.i_push_req(push), .i_pop_req(pop), .i_pop_discard(discard), .i_int_ack(int_ack),
		.i_int_high(int_high), .i_jump_req(jump), .i_jump_addr(jump_addr),
		.i_pcl_write(pcl_write), .i_pcl_data(pcl_data), .i_pc_step(step), .o_pc(pc),
		.i_pmem_rdata(pmem_rdata), .o_insn(insn), .o_stack_reset(stack_rst));

	ras_core_model i_ras_core_model (.i_mclk(mclk), .i_pc(pc), .o_dev_reset(dev_reset),
		.o_int_ack(int_ack), .o_int_high(int_high), .o_push(push), .o_pop(pop),
		.o_discard(discard), .o_jump(jump), .o_jump_addr(jump_addr),
		.o_pcl_write(pcl_write), .o_pcl_data(pcl_data), .o_step(step),
		.o_pmem_rdata(pmem_rdata));

	// clock and hang guard; the whole run needs well under a thousand cycles
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cycles++;
		if (stack_rst === 1'b1) n_srst++;
		if (cycles == 4000) begin
			n_mismatch++;
			end_of_test();
		end
	end

	task automatic end_of_test();
		$display("comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %0h, seen %0h", what, exp, got);
		end
	endtask

	// avalon read: request held until waitrequest is sampled low, data taken at that edge
	task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp, input string what);
		@(posedge mclk);
		avs_read <= 1'b1;
		avs_address <= a;
		do @(posedge mclk); while (avs_waitrequest !== 1'b0);
		check(what, exp, avs_readdata);
		avs_read <= 1'b0;
	endtask

	task automatic bus_wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
		@(posedge mclk);
		avs_write <= 1'b1;
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		do @(posedge mclk); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
	endtask

	// outputs are compared mid-cycle, clear of the launching edge
	task automatic pc_chk(input ras_pc_t exp);
		@(negedge mclk);
		check("pc", 32'(exp), 32'(pc));
	endtask

	task automatic fetch_chk(input logic [8:0] sel, input ras_pc_t a, input logic [15:0] exp);
		i_ras_core_model.op(sel, a);
		repeat (4) @(posedge mclk);
		pc_chk(sel == K_STEP ? 21'h008000 : a);
		check("insn", 32'(exp), 32'(insn));
	endtask

	initial begin
		arst_n = 1'b0;
		{avs_read, avs_write} = 2'b00;
		avs_address = 5'h00;
		avs_writedata = 32'h00000000;
		avs_byteenable = 4'h0;
		repeat (4) @(posedge mclk);
		arst_n <= 1'b1;
		pc_chk(`RAS_RESET_VEC);
		rd_chk(`RAS_OFF_SP, 32'h00, "pointer");
		rd_chk(`RAS_OFF_CTRL, 32'h01, "control");
		bus_wr(5'h02, 32'hFF, 4'hF);
		rd_chk(5'h02, 32'h00, "unmapped");
		bus_wr(`RAS_OFF_SP, 32'h05, 4'hE);
		rd_chk(`RAS_OFF_SP, 32'h00, "pointer masked");
		// call, then both interrupt vectors nested on top
		i_ras_core_model.op(K_JMP, 21'h123456);
		i_ras_core_model.op(K_PUSH | K_JMP, 21'h1ABCDE);
		pc_chk(21'h1ABCDE);
		rd_chk(`RAS_OFF_SP, 32'h01, "pointer");
		rd_chk(`RAS_OFF_TOP_ENTRY_LOW_BYTE, 32'h56, "top low");
		rd_chk(`RAS_OFF_TOP_ENTRY_HIGH_BYTE, 32'h34, "top high");
		rd_chk(`RAS_OFF_TOP_ENTRY_UPPER_BYTE, 32'h12, "top upper");
		i_ras_core_model.op(K_INT | K_HI, 21'h000000);
		pc_chk(`RAS_VEC_HI);
		i_ras_core_model.op(K_INT, 21'h000000);
		pc_chk(`RAS_VEC_LO);
		rd_chk(`RAS_OFF_SP, 32'h03, "pointer");
		rd_chk(`RAS_OFF_TOP_ENTRY_LOW_BYTE, 32'h08, "top low");
		i_ras_core_model.op(K_POP, 21'h000000);
		pc_chk(21'h000008);
		// patch one byte of the return address with the core quiet
		bus_wr(`RAS_OFF_TOP_ENTRY_LOW_BYTE, 32'hEF, 4'h1);
		rd_chk(`RAS_OFF_TOP_ENTRY_HIGH_BYTE, 32'hBC, "top high");
		rd_chk(`RAS_OFF_TOP_ENTRY_UPPER_BYTE, 32'h1A, "top upper");
		bus_wr(`RAS_OFF_LATH, 32'h55, 4'h1);
		bus_wr(`RAS_OFF_LATU, 32'h0A, 4'h1);
		i_ras_core_model.op(K_POP, 21'h000000);
		pc_chk(21'h1ABCEF);
		rd_chk(`RAS_OFF_LATH, 32'h55, "latch high");
		rd_chk(`RAS_OFF_LATU, 32'h0A, "latch upper");
		i_ras_core_model.op(K_PCL, 21'h000066);
		pc_chk(21'h0A5566);
		rd_chk(`RAS_OFF_PC, 32'h0A5566, "pc register");
		i_ras_core_model.op(K_DISC, 21'h000000);
		pc_chk(21'h0A5566);
		rd_chk(`RAS_OFF_TOP_ENTRY_LOW_BYTE, 32'h00, "empty top");
		i_ras_core_model.op(K_POP, 21'h000000);
		pc_chk(21'h000000);
		rd_chk(`RAS_OFF_SP, 32'h40, "underflow");
		check("stack resets", 32'd1, 32'(n_srst));
		bus_wr(`RAS_OFF_SP, 32'h00, 4'h1);
		rd_chk(`RAS_OFF_SP, 32'h00, "flags cleared");
		// fetches either side of the implemented memory
		fetch_chk(K_JMP, 21'h007FFE, 16'h7FFE ^ 16'h5A5A);
		fetch_chk(K_STEP, 21'h000000, 16'h0000);
		fetch_chk(K_JMP, 21'h1FFFFE, 16'h0000);
		// overflow with the reset option off
		bus_wr(`RAS_OFF_CTRL, 32'h00, 4'h1);
		i_ras_core_model.op(K_JMP, 21'h000000);
		for (int k = 1; k <= 32; k++) begin
			i_ras_core_model.op(K_PUSH | K_JMP, 21'(k * 4));
			if (k == 30) rd_chk(`RAS_OFF_SP, 32'h1E, "pointer");
			if (k == 31) rd_chk(`RAS_OFF_SP, 32'h9F, "full");
		end
		rd_chk(`RAS_OFF_SP, 32'h9F, "full held");
		rd_chk(`RAS_OFF_TOP_ENTRY_LOW_BYTE, 32'h7C, "overwritten top");
		i_ras_core_model.op(K_RST, 21'h000000);
		pc_chk(21'h000000);
		rd_chk(`RAS_OFF_SP, 32'h80, "flags kept");
		// power-on reset in mid-run clears the sticky flags and turns the option back on
		arst_n <= 1'b0;
		@(posedge mclk);
		arst_n <= 1'b1;
		rd_chk(`RAS_OFF_SP, 32'h00, "flags after power-on");
		rd_chk(`RAS_OFF_CTRL, 32'h01, "control after power-on");
		// overflow with the reset option on, started from pointer 30
		bus_wr(`RAS_OFF_SP, 32'h00, 4'h1);
		bus_wr(`RAS_OFF_CTRL, 32'h01, 4'h1);
		bus_wr(`RAS_OFF_SP, 32'h1E, 4'h1);
		i_ras_core_model.op(K_JMP, 21'h000040);
		i_ras_core_model.op(K_PUSH, 21'h000000);
		pc_chk(21'h000000);
		rd_chk(`RAS_OFF_SP, 32'h80, "full reset");
		bus_wr(`RAS_OFF_SP, 32'h9F, 4'h1);
		rd_chk(`RAS_OFF_TOP_ENTRY_LOW_BYTE, 32'h42, "pc plus two");
		check("stack resets", 32'd2, 32'(n_srst));
		end_of_test();
	end
endmodule
